// ### core/fsq_pkg.sv
// Notes on behaviour
// - in data mode, read-page copies the addressed 4-byte page into the holding bytes
// - in load mode, write-page programs XRAM bytes 0..255 into page high; high below E0H
// - in data mode, verify compares holding bytes; command readback zero on match
// - verify is not implemented in load mode; software reads back instead
// - in data mode, erase-page erases the addressed 4-byte data page
// - in load mode, erase-page erases the 64-byte program page holding the address
// - in data mode, erase-all erases the whole 4-kbyte data array
// - in load mode, erase-all erases the whole 56-kbyte program region
// - in data mode, read-byte loads the addressed byte, up to 0FFFH, into holding byte one
// - write-byte programs holding byte one; program memory up to DFFFH in load mode
// - exit-load code selects data-memory mode, or keeps it
// - enter-load code selects program-load mode, or keeps it
// - data mode read-page and verify take 22 machine cycles, read-byte 9
// - data page write takes 380 us, single-byte write 200 us
// - page erase and erase-all take 2 ms in both modes
// - load mode 256-byte page programming takes 16.5 ms
// - the operation starts as soon as the command code is written
// - the core is held from command write until the operation completes
// - interrupts are held off during the operation; timers keep running
package fsq_pkg;
  localparam logic [7:0] CMD_READ_PAGE = 8'h01;
  localparam logic [7:0] CMD_WRITE_PAGE = 8'h02;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  localparam logic [7:0] CMD_READ_BYTE = 8'h81;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h82;
  localparam logic [7:0] CMD_EXIT_LOAD = 8'h0F;
  localparam logic [7:0] CMD_ENTER_LOAD = 8'hF0;
  localparam logic [7:0] VERIFY_OK = 8'h00;
  localparam logic [7:0] VERIFY_BAD = 8'h01;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic MODE_RESET = 1'b0;

  localparam int DATA_BYTES = 4096;
  localparam int PROG_BYTES = 57344;
  localparam logic [15:0] DATA_PAGE_LIMIT = 16'h0400;
  localparam logic [15:0] DATA_BYTE_MAX = 16'h0FFF;
  localparam logic [15:0] PROG_BYTE_MAX = 16'hDFFF;
  localparam logic [7:0] PROG_PAGE_LIMIT = 8'hE0;
  localparam logic [15:0] LEN_DATA_PAGE = 16'h0004;
  localparam logic [15:0] LEN_PROG_ERASE = 16'h0040;
  localparam logic [15:0] LEN_PROG_PAGE = 16'h0100;
  localparam logic [15:0] LEN_BYTE = 16'h0001;

  localparam int TMR_W = 21;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MC_CLKS = 1;
  localparam int READ_PAGE_MC = 22;
  localparam int VERIFY_MC = 22;
  localparam int READ_BYTE_MC = 9;
  localparam int T_WRITE_PAGE_NS = 380000;
  localparam int T_WRITE_BYTE_NS = 200000;
  localparam int T_ERASE_NS = 2000000;
  localparam int T_PROG_PAGE_NS = 16500000;
  localparam int WRITE_PAGE_CLKS = T_WRITE_PAGE_NS / CLK_PERIOD_NS;
  localparam int WRITE_BYTE_CLKS = T_WRITE_BYTE_NS / CLK_PERIOD_NS;
  localparam int ERASE_CLKS = T_ERASE_NS / CLK_PERIOD_NS;
  localparam int PROG_PAGE_CLKS = T_PROG_PAGE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_WAIT = 3'b100
  } fsq_state_t;
endpackage

// ### core/fsq_mem.sv
`timescale 1ns/1ps
`default_nettype none
// byte array with one write port and one registered read port
module fsq_mem #(
  parameter int AW = 12,
  parameter int DEPTH = 4096
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### core/fsq_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter; expired once the loaded count has run out
module fsq_timer #(
  parameter int W = 21
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic expired
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0);
endmodule
`default_nettype wire

// ### core/fsq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module fsq_sequencer #(
  parameter int MACHINE_CYCLE_CLKS = fsq_pkg::MC_CLKS,
  parameter int WRITE_PAGE_CLKS = fsq_pkg::WRITE_PAGE_CLKS,
  parameter int WRITE_BYTE_CLKS = fsq_pkg::WRITE_BYTE_CLKS,
  parameter int ERASE_CLKS = fsq_pkg::ERASE_CLKS,
  parameter int PROG_PAGE_CLKS = fsq_pkg::PROG_PAGE_CLKS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] WR_DATA,
  input wire logic CMD_WE,
  input wire logic ADDR_HI_WE,
  input wire logic ADDR_LO_WE,
  input wire logic [3:0] DATA_WE,
  input wire logic [7:0] XRAM_RDATA,
  input wire logic [15:0] PMEM_RADDR,
  output logic [7:0] CMD_RDATA,
  output logic [7:0] ADDR_HI,
  output logic [7:0] ADDR_LO,
  output logic [31:0] DATA_HOLD,
  output logic PROG_MODE,
  output logic CORE_HOLD,
  output logic IRQ_HOLD,
  output logic [7:0] XRAM_ADDR,
  output logic [7:0] PMEM_RDATA
);
  import fsq_pkg::*;

  fsq_state_t state_q;
  logic prog_q, pend_q, mism_q, busy_q;
  logic [7:0] cmd_q, op_q, hi_q, lo_q, xram_addr_q;
  logic [7:0] hold_q [4];
  logic [15:0] base_q, len_q, idx_q, pidx_q;
  logic idle, cmd_go, dec_ok, page_ok, issue;
  logic [15:0] dec_base, dec_len, byte_addr, rd_addr, wr_addr;
  logic [TMR_W-1:0] dec_dur;
  logic is_write, is_read, is_verify, fill, from_xram;
  logic [7:0] wr_byte, dmem_rdata;
  logic dmem_we, pmem_we, tmr_expired;

  assign idle = (state_q == ST_IDLE);
  assign cmd_go = CMD_WE && idle;
  assign byte_addr = {hi_q, lo_q};
  assign page_ok = (byte_addr < DATA_PAGE_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // command decode against the current mode and address
  always_comb begin
    dec_ok = 1'b0;
    dec_base = 16'h0000;
    dec_len = LEN_DATA_PAGE;
    dec_dur = TMR_W'(ERASE_CLKS);
    unique case (WR_DATA)
      CMD_READ_PAGE: begin
        dec_ok = !prog_q && page_ok;
        dec_base = {byte_addr[13:0], 2'b00};
        dec_dur = TMR_W'(READ_PAGE_MC * MACHINE_CYCLE_CLKS);
      end
      CMD_VERIFY: begin
        dec_ok = !prog_q && page_ok;
        dec_base = {byte_addr[13:0], 2'b00};
        dec_dur = TMR_W'(VERIFY_MC * MACHINE_CYCLE_CLKS);
      end
      CMD_WRITE_PAGE: begin
        if (prog_q) begin
          dec_ok = (hi_q < PROG_PAGE_LIMIT);
          dec_base = {hi_q, 8'h00};
          dec_len = LEN_PROG_PAGE;
          dec_dur = TMR_W'(PROG_PAGE_CLKS);
        end else begin
          dec_ok = page_ok;
          dec_base = {byte_addr[13:0], 2'b00};
          dec_dur = TMR_W'(WRITE_PAGE_CLKS);
        end
      end
      CMD_ERASE_PAGE: begin
        if (prog_q) begin
          dec_ok = (hi_q < PROG_PAGE_LIMIT);
          dec_base = {hi_q, lo_q[7:6], 6'b000000};
          dec_len = LEN_PROG_ERASE;
        end else begin
          dec_ok = page_ok;
          dec_base = {byte_addr[13:0], 2'b00};
        end
      end
      CMD_ERASE_ALL: begin
        dec_ok = 1'b1;
        dec_len = prog_q ? 16'(PROG_BYTES) : 16'(DATA_BYTES);
      end
      CMD_READ_BYTE: begin
        dec_ok = !prog_q && (byte_addr <= DATA_BYTE_MAX);
        dec_base = byte_addr;
        dec_len = LEN_BYTE;
        dec_dur = TMR_W'(READ_BYTE_MC * MACHINE_CYCLE_CLKS);
      end
      CMD_WRITE_BYTE: begin
        dec_ok = (byte_addr <= (prog_q ? PROG_BYTE_MAX : DATA_BYTE_MAX));
        dec_base = byte_addr;
        dec_len = LEN_BYTE;
        dec_dur = TMR_W'(WRITE_BYTE_CLKS);
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: the walk over the bytes runs under the timer, and the
  // hold is released only once both are done
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      op_q <= CMD_RESET;
      base_q <= 16'h0000;
      len_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cmd_go && dec_ok) begin
            state_q <= ST_XFER;
            busy_q <= 1'b1;
            op_q <= WR_DATA;
            base_q <= dec_base;
            len_q <= dec_len;
          end
        end
        ST_XFER: begin
          if (!issue && !pend_q) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tmr_expired) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  fsq_timer #(.W(TMR_W)) u_timer (
    .clk(CLK),
    .rst(SYS_RST),
    .load(cmd_go && dec_ok),
    .count(dec_dur),
    .expired(tmr_expired)
  );

  // one access issued per cycle, acted on one cycle later when read data land
  assign issue = (state_q == ST_XFER) && (idx_q < len_q);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idx_q <= 16'h0000;
      pidx_q <= 16'h0000;
      pend_q <= 1'b0;
      xram_addr_q <= 8'h00;
    end else begin
      pend_q <= issue;
      if (idle) begin
        idx_q <= 16'h0000;
      end else if (issue) begin
        idx_q <= idx_q + 16'h0001;
        pidx_q <= idx_q;
        xram_addr_q <= idx_q[7:0];
      end
    end
  end

  assign is_write = (op_q == CMD_WRITE_PAGE) || (op_q == CMD_WRITE_BYTE) || fill;
  assign fill = (op_q == CMD_ERASE_PAGE) || (op_q == CMD_ERASE_ALL);
  assign is_read = (op_q == CMD_READ_PAGE) || (op_q == CMD_READ_BYTE);
  assign is_verify = (op_q == CMD_VERIFY);
  assign from_xram = prog_q && (op_q == CMD_WRITE_PAGE);
  assign wr_byte = fill ? ERASED : (from_xram ? XRAM_RDATA : hold_q[pidx_q[1:0]]);
  assign rd_addr = base_q + idx_q;
  assign wr_addr = base_q + pidx_q;
  // mode cannot change mid-operation, so prog_q steers the target array
  assign dmem_we = pend_q && is_write && !prog_q;
  assign pmem_we = pend_q && is_write && prog_q;

  fsq_mem #(.AW(12), .DEPTH(DATA_BYTES)) u_data_mem (
    .clk(CLK),
    .we(dmem_we),
    .waddr(wr_addr[11:0]),
    .wdata(wr_byte),
    .raddr(rd_addr[11:0]),
    .rdata_q(dmem_rdata)
  );

  fsq_mem #(.AW(16), .DEPTH(PROG_BYTES)) u_prog_mem (
    .clk(CLK),
    .we(pmem_we),
    .waddr(wr_addr),
    .wdata(wr_byte),
    .raddr(PMEM_RADDR),
    .rdata_q(PMEM_RDATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode, command readback and address registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prog_q <= MODE_RESET;
    end else if (cmd_go && (WR_DATA == CMD_ENTER_LOAD)) begin
      prog_q <= 1'b1;
    end else if (cmd_go && (WR_DATA == CMD_EXIT_LOAD)) begin
      prog_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mism_q <= 1'b0;
    end else if (cmd_go) begin
      mism_q <= 1'b0;
    end else if (pend_q && is_verify && (dmem_rdata != hold_q[pidx_q[1:0]])) begin
      mism_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_q <= CMD_RESET;
    end else if (cmd_go) begin
      cmd_q <= WR_DATA;
    end else if (state_q == ST_WAIT && tmr_expired && is_verify) begin
      cmd_q <= mism_q ? VERIFY_BAD : VERIFY_OK;
    end
  end

  // writes from the core while held cannot happen; ignoring them is a guard
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      if (ADDR_HI_WE && idle) begin
        hi_q <= WR_DATA;
      end
      if (ADDR_LO_WE && idle) begin
        lo_q <= WR_DATA;
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_hold
    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        hold_q[i] <= 8'h00;
      end else if (pend_q && is_read && (pidx_q[1:0] == 2'(i))) begin
        hold_q[i] <= dmem_rdata;
      end else if (DATA_WE[i] && idle) begin
        hold_q[i] <= WR_DATA;
      end
    end
    assign DATA_HOLD[8*i+7:8*i] = hold_q[i];
  end

  assign CMD_RDATA = cmd_q;
  assign ADDR_HI = hi_q;
  assign ADDR_LO = lo_q;
  assign PROG_MODE = prog_q;
  assign CORE_HOLD = busy_q;
  assign IRQ_HOLD = busy_q;
  assign XRAM_ADDR = xram_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [TMR_W:0] busy_len_q;
  logic [TMR_W-1:0] dur_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_len_q <= '0;
      dur_q <= '0;
    end else if (cmd_go && dec_ok) begin
      busy_len_q <= '0;
      dur_q <= dec_dur;
    end else if (busy_q) begin
      busy_len_q <= busy_len_q + 1'b1;
    end
  end

  sequence s_start_op;
    CMD_WE && idle && dec_ok;
  endsequence

  sequence s_dead_code;
    CMD_WE && idle && prog_q &&
      (WR_DATA == CMD_READ_PAGE || WR_DATA == CMD_VERIFY || WR_DATA == CMD_READ_BYTE);
  endsequence

  a_hold_on_write: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_start_op |=> CORE_HOLD ##1 CORE_HOLD) else $error("core not held after command");
  a_irq_tracks_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    IRQ_HOLD == CORE_HOLD) else $error("interrupt hold differs from core hold");
  a_hold_min_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    $fell(CORE_HOLD) |-> busy_len_q >= (TMR_W+1)'(dur_q)) else $error("operation ended early");
  a_mode_enter: assert property (@(posedge CLK) disable iff (SYS_RST)
    CMD_WE && idle && WR_DATA == CMD_ENTER_LOAD |=> PROG_MODE) else $error("load mode not set");
  a_mode_exit: assert property (@(posedge CLK) disable iff (SYS_RST)
    CMD_WE && idle && WR_DATA == CMD_EXIT_LOAD |=> !PROG_MODE) else $error("data mode not set");
  a_dead_code_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_dead_code |=> (!CORE_HOLD && !dmem_we && !pmem_we) [*2]) else $error("dead code started work");
  a_verify_result: assert property (@(posedge CLK) disable iff (SYS_RST)
    $fell(CORE_HOLD) && is_verify |-> (CMD_RDATA == VERIFY_OK) == !$past(mism_q))
    else $error("verify readback wrong");
  a_erase_fills: assert property (@(posedge CLK) disable iff (SYS_RST)
    (dmem_we || pmem_we) && fill |-> wr_byte == ERASED) else $error("erase wrote non-erased byte");
  a_erase_span: assert property (@(posedge CLK) disable iff (SYS_RST)
    (dmem_we || pmem_we) && op_q == CMD_ERASE_PAGE |->
      (prog_q ? wr_addr[15:6] == {ADDR_HI, ADDR_LO[7:6]} : wr_addr[11:2] == {ADDR_HI[1:0], ADDR_LO}))
    else $error("page erase left its page");
  a_prog_range: assert property (@(posedge CLK) disable iff (SYS_RST)
    pmem_we |-> wr_addr <= PROG_BYTE_MAX) else $error("program write out of range");
  a_read_lands: assert property (@(posedge CLK) disable iff (SYS_RST)
    pend_q && op_q == CMD_READ_BYTE |=> DATA_HOLD[7:0] == $past(dmem_rdata))
    else $error("read byte not captured");
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fsq_pkg::*;
  // short durations keep the run small; the sequencer waits for its byte walk as well
  localparam int WP = 400;
  localparam int WB = 300;
  localparam int ER = 60;
  localparam int PP = 500;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] WR_DATA = 8'h00;
  logic CMD_WE = 1'b0;
  logic ADDR_HI_WE = 1'b0;
  logic ADDR_LO_WE = 1'b0;
  logic [3:0] DATA_WE = 4'h0;
  logic [7:0] XRAM_RDATA;
  logic [15:0] PMEM_RADDR = 16'h0000;
  logic [7:0] CMD_RDATA, ADDR_HI, ADDR_LO, XRAM_ADDR, PMEM_RDATA;
  logic [31:0] DATA_HOLD;
  logic PROG_MODE, CORE_HOLD, IRQ_HOLD;
  int bad_count = 0;
  int num_checks = 0;
  // xram contents are a pattern of the index, so every byte of a page differs
  assign XRAM_RDATA = XRAM_ADDR ^ 8'h5A;
  always #5 CLK = ~CLK;
  fsq_sequencer #(.MACHINE_CYCLE_CLKS(1), .WRITE_PAGE_CLKS(WP), .WRITE_BYTE_CLKS(WB),
    .ERASE_CLKS(ER), .PROG_PAGE_CLKS(PP)) dut (.CLK(CLK), .SYS_RST(SYS_RST), .WR_DATA(WR_DATA),
    .CMD_WE(CMD_WE), .ADDR_HI_WE(ADDR_HI_WE), .ADDR_LO_WE(ADDR_LO_WE), .DATA_WE(DATA_WE),
    .XRAM_RDATA(XRAM_RDATA), .PMEM_RADDR(PMEM_RADDR), .CMD_RDATA(CMD_RDATA), .ADDR_HI(ADDR_HI),
    .ADDR_LO(ADDR_LO), .DATA_HOLD(DATA_HOLD), .PROG_MODE(PROG_MODE), .CORE_HOLD(CORE_HOLD),
    .IRQ_HOLD(IRQ_HOLD), .XRAM_ADDR(XRAM_ADDR), .PMEM_RDATA(PMEM_RDATA));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // sel 0 command, 1 addr high, 2 addr low, 3..6 holding bytes 0..3
  task automatic pulse(input int sel, input logic [7:0] d);
    @(posedge CLK);
    WR_DATA <= d;
    if (sel == 0) CMD_WE <= 1'b1;
    if (sel == 1) ADDR_HI_WE <= 1'b1;
    if (sel == 2) ADDR_LO_WE <= 1'b1;
    if (sel > 2) DATA_WE <= 4'h1 << (sel - 3);
    @(posedge CLK);
    CMD_WE <= 1'b0;
    ADDR_HI_WE <= 1'b0;
    ADDR_LO_WE <= 1'b0;
    DATA_WE <= 4'h0;
    #1;
  endtask
  task automatic setad(input logic [7:0] hi, input logic [7:0] lo);
    pulse(1, hi);
    pulse(2, lo);
    chk("addr_regs", {hi, lo}, {ADDR_HI, ADDR_LO});
  endtask
  task automatic setdata(input logic [31:0] v);
    for (int i = 0; i < 4; i++) pulse(3 + i, v[8*i +: 8]);
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (CORE_HOLD === 1'b1 && n < 70000) begin
      chk("irq_hold", 1'b1, IRQ_HOLD);
      @(posedge CLK);
      #1;
      n++;
    end
    chk("irq_free", 1'b0, IRQ_HOLD);
  endtask
  task automatic cmd(input logic [7:0] code, input logic hold, input int lo, input int hi);
    int n;
    pulse(0, code);
    chk("core_hold", hold, CORE_HOLD);
    chk("cmd_rdata", code, CMD_RDATA);
    wait_idle(n);
    if (hold) begin
      num_checks++;
      if (n < lo || n > hi) begin
        bad_count++;
        $display("[ERR] hold_cycles expected %0d..%0d seen %0d", lo, hi, n);
      end
    end
  endtask
  task automatic rdp(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK);
    PMEM_RADDR <= a;
    repeat (2) @(posedge CLK);
    #1;
    chk("pmem_rdata", exp, PMEM_RDATA);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("outs_in_reset", 32'h0, {CMD_RDATA, ADDR_HI, ADDR_LO, XRAM_ADDR});
    chk("mode_reset", MODE_RESET, PROG_MODE);
    chk("hold_reset", 32'h0, DATA_HOLD);
    chk("busy_reset", 32'h0, {CORE_HOLD, IRQ_HOLD});
  endtask
  task automatic t_data();
    cmd(CMD_ERASE_ALL, 1, ER, ER + 4100);
    setad(8'h00, 8'h03);
    setdata(32'hA1B2_C3D4);
    cmd(CMD_WRITE_PAGE, 1, WP, WP + 8);
    setdata(32'h0000_0000);
    cmd(CMD_READ_PAGE, 1, 22, 30);
    chk("read_page", 32'hA1B2_C3D4, DATA_HOLD);
    cmd(CMD_VERIFY, 1, 22, 30);
    chk("verify_ok", VERIFY_OK, CMD_RDATA);
    pulse(5, 8'h00);
    cmd(CMD_VERIFY, 1, 22, 30);
    chk("verify_bad", VERIFY_BAD, CMD_RDATA);
    setad(8'h00, 8'h0D);
    cmd(CMD_READ_BYTE, 1, 9, 16);
    chk("read_byte", 8'hC3, DATA_HOLD[7:0]);
    setad(8'h0F, 8'hFF);
    pulse(3, 8'h3C);
    cmd(CMD_WRITE_BYTE, 1, WB, WB + 6);
    pulse(3, 8'h00);
    cmd(CMD_READ_BYTE, 1, 9, 16);
    chk("write_byte_top", 8'h3C, DATA_HOLD[7:0]);
    setad(8'h00, 8'h03);
    cmd(CMD_ERASE_PAGE, 1, ER, ER + 8);
    cmd(CMD_READ_PAGE, 1, 22, 30);
    chk("erase_page", 32'hFFFF_FFFF, DATA_HOLD);
  endtask
  task automatic t_refuse();
    int n;
    logic [7:0] bad [3] = '{8'h03, 8'h07, 8'h80};
    setdata(32'h1122_3344);
    foreach (bad[i]) cmd(bad[i], 0, 0, 0);
    setad(8'h10, 8'h00);
    cmd(CMD_READ_BYTE, 0, 0, 0);
    setad(8'h04, 8'h00);
    cmd(CMD_READ_PAGE, 0, 0, 0);
    chk("hold_kept", 32'h1122_3344, DATA_HOLD);
    setad(8'h00, 8'h05);
    pulse(0, CMD_ERASE_PAGE);
    pulse(3, 8'h77);
    wait_idle(n);
    chk("write_in_hold", 32'h1122_3344, DATA_HOLD);
  endtask
  task automatic t_load();
    cmd(CMD_ENTER_LOAD, 0, 0, 0);
    chk("enter_load", 1'b1, PROG_MODE);
    cmd(CMD_ENTER_LOAD, 0, 0, 0);
    chk("enter_again", 1'b1, PROG_MODE);
    cmd(CMD_READ_PAGE, 0, 0, 0);
    cmd(CMD_VERIFY, 0, 0, 0);
    cmd(CMD_READ_BYTE, 0, 0, 0);
    // program bytes are only written once erased, so the whole region goes first
    cmd(CMD_ERASE_ALL, 1, ER, ER + 57350);
    rdp(16'h0000, ERASED);
    rdp(16'hDFFF, ERASED);
    setad(8'h01, 8'h00);
    cmd(CMD_WRITE_PAGE, 1, PP, PP + 262);
    rdp(16'h0100, 8'h5A);
    rdp(16'h01FF, 8'hA5);
    setad(8'h01, 8'h45);
    cmd(CMD_ERASE_PAGE, 1, ER, ER + 70);
    rdp(16'h0140, ERASED);
    rdp(16'h017F, ERASED);
    rdp(16'h013F, 8'h65);
    rdp(16'h0180, 8'hDA);
    setad(8'h01, 8'h50);
    pulse(3, 8'h96);
    cmd(CMD_WRITE_BYTE, 1, WB, WB + 6);
    rdp(16'h0150, 8'h96);
    setad(8'hE0, 8'h00);
    cmd(CMD_WRITE_PAGE, 0, 0, 0);
    cmd(CMD_WRITE_BYTE, 0, 0, 0);
    cmd(CMD_EXIT_LOAD, 0, 0, 0);
    chk("exit_load", 1'b0, PROG_MODE);
    cmd(CMD_EXIT_LOAD, 0, 0, 0);
    chk("exit_again", 1'b0, PROG_MODE);
    setad(8'h0F, 8'hFF);
    cmd(CMD_READ_BYTE, 1, 9, 16);
    chk("data_untouched", 8'h3C, DATA_HOLD[7:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge CLK);
    #1;
    t_reset();
    @(posedge CLK);
    SYS_RST <= 1'b0;
    t_data();
    t_refuse();
    t_load();
    close_out();
  end
  // the program erase-all walk dominates; the whole run needs about 65000 cycles
  initial begin
    repeat (90000) @(posedge CLK);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
